// >>> hdl/ubsam_pkg.sv
// Package for baud select and address match block
package ubsam_pkg;

   // APB register offsets (byte addresses, chosen)
   localparam logic [7:0] OFS_BAUD_GEN_CTRL = 8'h00;
   localparam logic [7:0] OFS_SERIAL_CTRL   = 8'h04;
   localparam logic [7:0] OFS_OWN_ADDR      = 8'h08;
   localparam logic [7:0] OFS_ADDR_MASK     = 8'h0C;
   localparam logic [7:0] OFS_RELOAD        = 8'h10;
   localparam logic [7:0] OFS_STATUS        = 8'h14;

   // baud_gen_ctrl fields
   localparam int BIT_RX_SRC  = 0;
   localparam int BIT_TX_SRC  = 1;
   localparam int BIT_PRESC   = 2;
   localparam int BIT_GEN_EN  = 3;
   localparam int BIT_DOUBLER = 4;
   // serial_ctrl fields
   localparam int BIT_MODE_LO = 0;
   localparam int BIT_MULTIP  = 2;
   localparam int BIT_RX_DONE = 3;
   localparam int BIT_RX_NINE = 4;

   localparam logic [7:0] RST_OWN_ADDR  = 8'h00;
   localparam logic [7:0] RST_ADDR_MASK = 8'h00;
   localparam logic [7:0] RST_RELOAD    = 8'h00;
   localparam logic [7:0] RST_CTRL      = 8'h00;

   // Divider constants
   localparam int GEN_DIV_BASE = 32;
   localparam int PRESC_DIV    = 6;
   localparam int T1_FRAME_DIV = 192;
   localparam int MODE2_DIV_HI = 16;
   localparam int MODE2_DIV_LO = 32;
   localparam int DIV_DOUBLE   = 16;

   typedef enum logic [1:0] {
      UBSAM_MODE0,
      UBSAM_MODE1,
      UBSAM_MODE2,
      UBSAM_MODE3
   } ubsam_mode_t;

   typedef struct packed {
      logic [7:0] data;
      logic       ninth;
      logic       stopOk;
   } ubsam_frame_t;

   typedef struct packed {
      logic [7:0] ownAddr;
      logic [7:0] addrMask;
   } ubsam_addr_t;

endpackage : ubsam_pkg

// >>> hdl/ubsam_tick_div.sv
// Free running tick divider, one pulse per period
`timescale 1ns/1ps
module ubsam_tick_div #(
   parameter int W = 16
) (
   input  wire logic         core_clk, // Clock
   input  wire logic         nrst,     // Async reset, active low
   input  wire logic         run,      // Count while high
   input  wire logic         tickIn,   // Count enable pulse
   input  wire logic [W-1:0] period,   // Ticks per output pulse
   output logic              tickOut   // One-cycle pulse
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= '0;
      end else if (!run) begin
         cnt_q <= '0;
      end else if (tickIn) begin
         if (cnt_q >= period - W'(1)) begin
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_q + W'(1);
         end
      end
   end

   assign tickOut = run && tickIn && (cnt_q >= period - W'(1));

endmodule : ubsam_tick_div

// >>> hdl/ubsam_addr_match.sv
// Masked given and broadcast address compare
`timescale 1ns/1ps
module ubsam_addr_match (
   input  wire ubsam_pkg::ubsam_addr_t cfg,   // Own address and mask
   input  wire logic [7:0]             rxAddr, // Received address byte
   output logic                        hit     // Given or broadcast hit
);
   logic [7:0] bcast;
   logic       givenHit;
   logic       bcastHit;

   assign givenHit = ((rxAddr ^ cfg.ownAddr) & cfg.addrMask) == 8'h00;
   assign bcast    = cfg.ownAddr | cfg.addrMask;
   assign bcastHit = ((rxAddr ^ bcast) & bcast) == 8'h00;
   assign hit      = givenHit || bcastHit;

endmodule : ubsam_addr_match

// >>> hdl/ubsam_top.sv
// Baud source selection and multiprocessor address filter
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module ubsam_top #(
   parameter int DIVW = 16
) (
   input  wire logic                    core_clk,   // 10 MHz clock
   input  wire logic                    nrst,       // Async reset, active low
   input  wire logic                    psel,       // APB select
   input  wire logic                    penable,    // APB enable
   input  wire logic                    pwrite,     // APB direction
   input  wire logic [7:0]              paddr,      // APB byte address
   input  wire logic [31:0]             pwdata,     // APB write data
   output logic [31:0]                  prdata,     // APB read data
   output logic                         pready,     // APB ready
   output logic                         pslverr,    // APB error
   input  wire logic                    timerOvf,   // Timer 1 overflow pulse
   input  wire logic [7:0]              timerReload,// Timer 1 reload byte
   input  wire logic                    frameValid, // Received frame pulse
   input  wire ubsam_pkg::ubsam_frame_t frameIn,    // Received frame
   output logic                         rxTick,     // Receive baud tick
   output logic                         txTick,     // Transmit baud tick
   output logic                         rxAccept,   // Frame delivered pulse
   output logic [7:0]                   rxData,     // Delivered byte
   output logic                         rxDoneFlag  // Receive done flag
);
   logic [7:0]             baudGenCtrl_q;
   logic [7:0]             serialCtrl_q;
   logic [7:0]             reload_q;
   ubsam_pkg::ubsam_addr_t addr_q;
   logic                   rxNinth_q;
   logic                   rxDone_q;
   logic                   accept_q;
   logic [7:0]             rxData_q;
   logic                   pre6_q;
   logic [2:0]             pre6Cnt_q;
   logic                   genRun;
   logic                   genTick;
   logic                   genOvf;
   logic                   t1Run;
   logic                   t1Ovf;
   logic                   m2Tick;
   logic                   m2Run;
   logic [DIVW-1:0]        genPeriod;
   logic [DIVW-1:0]        m2Period;
   logic [DIVW-1:0]        frmPeriod;
   logic                   genFrame;
   logic                   t1Frame;
   logic                   doubler;
   logic                   prescBypass;
   logic                   multiproc;
   ubsam_pkg::ubsam_mode_t mode;
   logic                   addrHit;
   logic                   isAddr;
   logic                   keepFrame;
   logic                   nineBit;
   logic                   wrEn;
   logic                   rdEn;
   logic                   mapped;
   logic                   clrDone;

   assign doubler     = baudGenCtrl_q[ubsam_pkg::BIT_DOUBLER];
   assign prescBypass = baudGenCtrl_q[ubsam_pkg::BIT_PRESC];
   assign genRun      = baudGenCtrl_q[ubsam_pkg::BIT_GEN_EN];
   assign multiproc   = serialCtrl_q[ubsam_pkg::BIT_MULTIP];
   assign mode        = ubsam_pkg::ubsam_mode_t'(
                           serialCtrl_q[ubsam_pkg::BIT_MODE_LO +: 2]);

   // APB slave, zero wait states
   assign wrEn    = psel && penable && pwrite;
   assign rdEn    = psel && penable && !pwrite;
   assign pready  = 1'b1;
   assign mapped  = (paddr == ubsam_pkg::OFS_BAUD_GEN_CTRL)
                 || (paddr == ubsam_pkg::OFS_SERIAL_CTRL)
                 || (paddr == ubsam_pkg::OFS_OWN_ADDR)
                 || (paddr == ubsam_pkg::OFS_ADDR_MASK)
                 || (paddr == ubsam_pkg::OFS_RELOAD)
                 || (paddr == ubsam_pkg::OFS_STATUS);
   assign pslverr = psel && penable && !mapped;

   always_comb begin
      prdata = 32'h0000_0000;
      if (paddr == ubsam_pkg::OFS_BAUD_GEN_CTRL) begin
         prdata[7:0] = baudGenCtrl_q;
      end else if (paddr == ubsam_pkg::OFS_SERIAL_CTRL) begin
         prdata[7:0] = {serialCtrl_q[7:5], rxNinth_q, rxDone_q,
                        serialCtrl_q[2:0]};
      end else if (paddr == ubsam_pkg::OFS_OWN_ADDR) begin
         prdata[7:0] = addr_q.ownAddr;
      end else if (paddr == ubsam_pkg::OFS_ADDR_MASK) begin
         prdata[7:0] = addr_q.addrMask;
      end else if (paddr == ubsam_pkg::OFS_RELOAD) begin
         prdata[7:0] = reload_q;
      end else if (paddr == ubsam_pkg::OFS_STATUS) begin
         prdata[7:0] = {6'h00, rxNinth_q, rxDone_q};
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         baudGenCtrl_q <= ubsam_pkg::RST_CTRL;
         serialCtrl_q  <= ubsam_pkg::RST_CTRL;
         reload_q      <= ubsam_pkg::RST_RELOAD;
      end else if (wrEn) begin
         if (paddr == ubsam_pkg::OFS_BAUD_GEN_CTRL) begin
            baudGenCtrl_q <= pwdata[7:0];
         end else if (paddr == ubsam_pkg::OFS_SERIAL_CTRL) begin
            serialCtrl_q  <= pwdata[7:0];
         end else if (paddr == ubsam_pkg::OFS_RELOAD) begin
            reload_q      <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         addr_q.ownAddr  <= ubsam_pkg::RST_OWN_ADDR;
         addr_q.addrMask <= ubsam_pkg::RST_ADDR_MASK;
      end else if (wrEn && paddr == ubsam_pkg::OFS_OWN_ADDR) begin
         addr_q.ownAddr  <= pwdata[7:0];
      end else if (wrEn && paddr == ubsam_pkg::OFS_ADDR_MASK) begin
         addr_q.addrMask <= pwdata[7:0];
      end
   end

   // Divide by six unless prescale bypassed
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pre6Cnt_q <= 3'd0;
         pre6_q    <= 1'b0;
      end else begin
         pre6_q <= (pre6Cnt_q == 3'(ubsam_pkg::PRESC_DIV - 1));
         if (pre6Cnt_q == 3'(ubsam_pkg::PRESC_DIV - 1)) begin
            pre6Cnt_q <= 3'd0;
         end else begin
            pre6Cnt_q <= pre6Cnt_q + 3'd1;
         end
      end
   end

   assign genTick   = prescBypass ? 1'b1 : pre6_q;
   assign genPeriod = DIVW'(9'd256 - {1'b0, reload_q});
   // Doubler halves the 32 divide to 16
   assign frmPeriod = doubler ? DIVW'(ubsam_pkg::DIV_DOUBLE)
                              : DIVW'(ubsam_pkg::GEN_DIV_BASE);

   ubsam_tick_div #(.W(DIVW)) u_gen (
      .core_clk (core_clk),
      .nrst     (nrst),
      .run      (genRun),
      .tickIn   (genTick),
      .period   (genPeriod),
      .tickOut  (genOvf)
   );
   ubsam_tick_div #(.W(DIVW)) u_genFrm (
      .core_clk (core_clk),
      .nrst     (nrst),
      .run      (genRun),
      .tickIn   (genOvf),
      .period   (frmPeriod),
      .tickOut  (genFrame)
   );

   // Timer overflow counts 192/6 = 32 per bit
   assign t1Run = 1'b1;
   ubsam_tick_div #(.W(DIVW)) u_t1Frm (
      .core_clk (core_clk),
      .nrst     (nrst),
      .run      (t1Run),
      .tickIn   (timerOvf),
      .period   (DIVW'(ubsam_pkg::T1_FRAME_DIV / ubsam_pkg::PRESC_DIV)
                 >> doubler),
      .tickOut  (t1Ovf)
   );
   assign t1Frame = t1Ovf;

   assign m2Run    = (mode == ubsam_pkg::UBSAM_MODE2);
   assign m2Period = doubler ? DIVW'(ubsam_pkg::MODE2_DIV_HI)
                             : DIVW'(ubsam_pkg::MODE2_DIV_LO);
   ubsam_tick_div #(.W(DIVW)) u_m2 (
      .core_clk (core_clk),
      .nrst     (nrst),
      .run      (m2Run),
      .tickIn   (1'b1),
      .period   (m2Period),
      .tickOut  (m2Tick)
   );

   always_comb begin
      rxTick = 1'b0;
      txTick = 1'b0;
      case (mode)
         ubsam_pkg::UBSAM_MODE1, ubsam_pkg::UBSAM_MODE3: begin
            rxTick = baudGenCtrl_q[ubsam_pkg::BIT_RX_SRC] ? genFrame
                                                          : t1Frame;
            txTick = baudGenCtrl_q[ubsam_pkg::BIT_TX_SRC] ? genFrame
                                                          : t1Frame;
         end
         ubsam_pkg::UBSAM_MODE2: begin
            rxTick = m2Tick;
            txTick = m2Tick;
         end
         default: begin
            rxTick = 1'b0;
            txTick = 1'b0;
         end
      endcase
   end

   ubsam_addr_match u_match (
      .cfg    (addr_q),
      .rxAddr (frameIn.data),
      .hit    (addrHit)
   );

   // Stop bit stands in for ninth in mode 1
   assign nineBit = (mode == ubsam_pkg::UBSAM_MODE1) ? frameIn.stopOk
                                                     : frameIn.ninth;
   assign isAddr = multiproc && (mode != ubsam_pkg::UBSAM_MODE0);

   always_comb begin
      keepFrame = 1'b1;
      if (isAddr) begin
         keepFrame = nineBit && addrHit;
      end
   end

   assign clrDone = wrEn && (paddr == ubsam_pkg::OFS_SERIAL_CTRL)
                 && !pwdata[ubsam_pkg::BIT_RX_DONE];

   // Set beats software clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rxDone_q  <= 1'b0;
         rxNinth_q <= 1'b0;
         accept_q  <= 1'b0;
         rxData_q  <= 8'h00;
      end else begin
         accept_q <= frameValid && keepFrame;
         if (frameValid && keepFrame) begin
            rxDone_q  <= 1'b1;
            rxNinth_q <= nineBit;
            rxData_q  <= frameIn.data;
         end else if (clrDone) begin
            rxDone_q  <= 1'b0;
            rxNinth_q <= pwdata[ubsam_pkg::BIT_RX_NINE];
         end
      end
   end

   assign rxAccept   = accept_q;
   assign rxData     = rxData_q;
   assign rxDoneFlag = rxDone_q;

   property p_dropData;
      @(posedge core_clk) disable iff (!nrst)
      (frameValid && isAddr && !nineBit) |=> !accept_q;
   endproperty
   a_dropData: assert property (p_dropData) else $error("data kept");

   property p_hitSets;
      @(posedge core_clk) disable iff (!nrst)
      (frameValid && isAddr && nineBit && addrHit)
         |=> rxDone_q && rxNinth_q;
   endproperty
   a_hitSets: assert property (p_hitSets) else $error("hit lost");

   property p_mode0;
      @(posedge core_clk) disable iff (!nrst)
      (frameValid && mode == ubsam_pkg::UBSAM_MODE0) |=> accept_q;
   endproperty
   a_mode0: assert property (p_mode0) else $error("mode 0 filter");

   // Doubled tick spacing is sixteen cycles
   sequence s_m2Gap;
      !m2Tick [*8] ##1 !m2Tick [*7];
   endsequence

   property p_m2Quiet;
      @(posedge core_clk) disable iff (!nrst)
      (m2Tick && doubler) |=> s_m2Gap;
   endproperty
   a_m2Quiet: assert property (p_m2Quiet) else $error("mode 2 rate");

   property p_mode0Tick;
      @(posedge core_clk) disable iff (!nrst)
      (mode == ubsam_pkg::UBSAM_MODE0) |-> !rxTick && !txTick;
   endproperty
   a_mode0Tick: assert property (p_mode0Tick) else $error("tick m0");

   property p_srcSel;
      @(posedge core_clk) disable iff (!nrst)
      (mode == ubsam_pkg::UBSAM_MODE1
       && baudGenCtrl_q[ubsam_pkg::BIT_TX_SRC]) |-> txTick == genFrame;
   endproperty
   a_srcSel: assert property (p_srcSel) else $error("tx source");

   property p_resetAddr;
      @(posedge core_clk) $rose(nrst) |-> addr_q.ownAddr == 8'h00
         && addr_q.addrMask == 8'h00;
   endproperty
   a_resetAddr: assert property (p_resetAddr) else $error("addr rst");

   property p_stopMode1;
      @(posedge core_clk) disable iff (!nrst)
      (frameValid && isAddr && mode == ubsam_pkg::UBSAM_MODE1
       && !frameIn.stopOk) |=> !accept_q;
   endproperty
   a_stopMode1: assert property (p_stopMode1) else $error("bad stop");

   // Overflows arrive at most once a cycle, so sixteen is a floor
   sequence s_t1Gap;
      !t1Ovf [*8] ##1 !t1Ovf [*7];
   endsequence

   property p_t1Gap;
      @(posedge core_clk) disable iff (!nrst)
      (t1Ovf && doubler) |=> s_t1Gap;
   endproperty
   a_t1Gap: assert property (p_t1Gap) else $error("timer rate");

   property p_missKeeps;
      @(posedge core_clk) disable iff (!nrst)
      (frameValid && isAddr && !keepFrame && !clrDone)
         |=> $stable(rxDone_q) && $stable(rxNinth_q) && !accept_q;
   endproperty
   a_missKeeps: assert property (p_missKeeps) else $error("miss set");

endmodule : ubsam_top

// >>> tb/ubsam_peer.sv
// Serial master model: frame source and timer 1 overflow
`timescale 1ns/1ps
module ubsam_peer (
   input  wire logic               core_clk,   // Clock
   input  wire logic [3:0]         ovfGap,     // Cycles per overflow
   output logic                    timerOvf,   // Overflow pulse
   output logic                    frameValid, // Frame pulse
   output ubsam_pkg::ubsam_frame_t frameIn     // Frame content
);
   logic [3:0] gapCnt;

   initial begin
      gapCnt = 4'h0;
      timerOvf = 1'b0;
      frameValid = 1'b0;
      frameIn = '0;
   end

   // Timer keeps running whether or not it is selected
   always @(posedge core_clk) begin
      if (gapCnt + 4'h1 >= ovfGap) begin
         gapCnt <= 4'h0;
         timerOvf <= 1'b1;
      end else begin
         gapCnt <= gapCnt + 4'h1;
         timerOvf <= 1'b0;
      end
   end

   task automatic send(input logic [7:0] d, input logic n, input logic s);
      @(posedge core_clk);
      frameValid <= 1'b1;
      frameIn <= '{data: d, ninth: n, stopOk: s};
      @(posedge core_clk);
      frameValid <= 1'b0;
      // Stale frame never lingers after the pulse
      frameIn <= ~frameIn;
   endtask : send
endmodule : ubsam_peer

// >>> tb/ubsam_top_tb.sv
// Self-checking bench for baud select and address match
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module ubsam_top_tb;
   logic                    core_clk, nrst, psel, penable, pwrite;
   logic [7:0]              paddr;
   logic [31:0]             pwdata, prdata;
   logic                    pready, pslverr, timerOvf, frameValid;
   ubsam_pkg::ubsam_frame_t frameIn;
   logic                    rxTick, txTick, rxAccept, rxDoneFlag;
   logic [7:0]              rxData;
   logic [3:0]              ovfGap;
   int                      failures, cmp_count, accCnt, cyc;
   logic [1:0]              md [5] = '{2'h1, 2'h3, 2'h3, 2'h2, 2'h2};
   logic [7:0]              bg [5] = '{8'h0D, 8'h0A, 8'h1D, 8'h00, 8'h10};
   logic [7:0]              rl [5] = '{8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   logic [3:0]              gp [5] = '{4'h1, 4'h2, 4'h1, 4'h1, 4'h1};

   ubsam_top ubsam_top_inst (.core_clk(core_clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timerOvf(timerOvf), .timerReload(8'h00), .frameValid(frameValid),
      .frameIn(frameIn), .rxTick(rxTick), .txTick(txTick),
      .rxAccept(rxAccept), .rxData(rxData), .rxDoneFlag(rxDoneFlag));
   ubsam_peer ubsam_peer_inst (.core_clk(core_clk), .ovfGap(ovfGap),
      .timerOvf(timerOvf), .frameValid(frameValid), .frameIn(frameIn));

   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (rxAccept === 1'b1) accCnt <= accCnt + 1;
      cyc <= cyc + 1;
      // Tests need under 8000 cycles
      if (cyc == 20000) begin
         failures++;
         end_of_test();
      end
   end

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      // Wait states are the slave's; only the bench timeout ends this
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h00_0000, d}, r, e);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      `CHK(r, x)
   endtask : rd_chk

   function automatic logic tk(input logic tx);
      return tx ? txTick : rxTick;
   endfunction : tk

   function automatic int exp_per(input int i, input logic tx);
      int p;
      logic gen;
      gen = tx ? bg[i][ubsam_pkg::BIT_TX_SRC] : bg[i][ubsam_pkg::BIT_RX_SRC];
      if (md[i] == 2'h2) p = ubsam_pkg::MODE2_DIV_LO;
      else if (gen) p = (bg[i][ubsam_pkg::BIT_PRESC] ? 1 :
         ubsam_pkg::PRESC_DIV) * ubsam_pkg::GEN_DIV_BASE * (256 - rl[i]);
      else p = gp[i] * ubsam_pkg::GEN_DIV_BASE;
      if (bg[i][ubsam_pkg::BIT_DOUBLER]) p = p / 2;
      return p;
   endfunction : exp_per

   task automatic measure(input logic tx, output int p);
      int n;
      n = 0;
      // Skip pulses left over from the previous setting
      repeat (2) begin
         do begin
            @(posedge core_clk);
            n++;
         end while (tk(tx) !== 1'b1 && n < 3000);
      end
      p = 0;
      do begin
         @(posedge core_clk);
         p++;
      end while (tk(tx) !== 1'b1 && p < 3000);
   endtask : measure

   task automatic frame_chk(input logic [7:0] d, input logic n,
                            input logic s, input int keep);
      int b;
      b = accCnt;
      ubsam_peer_inst.send(d, n, s);
      repeat (3) @(posedge core_clk);
      `CHK(accCnt - b, keep)
      // Pulse over and never unknown
      `CHK(rxAccept, 1'b0)
      if (keep == 1) `CHK(rxData, d)
   endtask : frame_chk

   task automatic t_reset();
      logic [31:0] r;
      logic e;
      `CHK(rxDoneFlag, 1'b0)
      rd_chk(ubsam_pkg::OFS_OWN_ADDR, 32'h0000_0000);
      rd_chk(ubsam_pkg::OFS_ADDR_MASK, 32'h0000_0000);
      apb(1'b0, 8'h40, 32'h0000_0000, r, e);
      `CHK(e, 1'b1)
   endtask : t_reset

   task automatic t_rates();
      int p;
      for (int i = 0; i < 5; i++) begin
         wr(ubsam_pkg::OFS_BAUD_GEN_CTRL, bg[i]);
         wr(ubsam_pkg::OFS_RELOAD, rl[i]);
         wr(ubsam_pkg::OFS_SERIAL_CTRL, {6'h00, md[i]});
         ovfGap <= gp[i];
         measure(1'b0, p);
         `CHK(p, exp_per(i, 1'b0))
         measure(1'b1, p);
         `CHK(p, exp_per(i, 1'b1))
      end
   endtask : t_rates

   task automatic t_multiproc();
      wr(ubsam_pkg::OFS_SERIAL_CTRL, 8'h07);
      frame_chk(8'h9A, 1'b1, 1'b1, 1);
      wr(ubsam_pkg::OFS_OWN_ADDR, 8'h56);
      wr(ubsam_pkg::OFS_ADDR_MASK, 8'hFC);
      wr(ubsam_pkg::OFS_SERIAL_CTRL, 8'h07);
      frame_chk(8'h55, 1'b0, 1'b1, 0);
      `CHK(rxDoneFlag, 1'b0)
      frame_chk(8'h55, 1'b1, 1'b1, 1);
      `CHK(rxDoneFlag, 1'b1)
      rd_chk(ubsam_pkg::OFS_STATUS, 32'h0000_0003);
      wr(ubsam_pkg::OFS_SERIAL_CTRL, 8'h07);
      frame_chk(8'h66, 1'b1, 1'b1, 0);
      `CHK(rxDoneFlag, 1'b0)
      frame_chk(8'hFE, 1'b1, 1'b1, 1);
      wr(ubsam_pkg::OFS_ADDR_MASK, 8'hFF);
      frame_chk(8'h57, 1'b1, 1'b1, 0);
      frame_chk(8'h56, 1'b1, 1'b1, 1);
      wr(ubsam_pkg::OFS_SERIAL_CTRL, 8'h03);
      frame_chk(8'h21, 1'b0, 1'b1, 1);
      wr(ubsam_pkg::OFS_SERIAL_CTRL, 8'h05);
      frame_chk(8'h56, 1'b1, 1'b0, 0);
      frame_chk(8'h56, 1'b0, 1'b1, 1);
      wr(ubsam_pkg::OFS_SERIAL_CTRL, 8'h04);
      frame_chk(8'h33, 1'b0, 1'b0, 1);
   endtask : t_multiproc

   // Reset in mid-run, after address, mask and done flag were set
   task automatic t_rerun();
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      t_reset();
      wr(ubsam_pkg::OFS_SERIAL_CTRL, 8'h07);
      frame_chk(8'hC3, 1'b1, 1'b1, 1);
   endtask : t_rerun

   task end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   initial begin
      failures = 0;
      cmp_count = 0;
      accCnt = 0;
      cyc = 0;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      ovfGap = 4'h1;
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_rates();
      t_multiproc();
      t_rerun();
      end_of_test();
   end
endmodule : ubsam_top_tb
